// [logic/bsp_pkg.sv]
/*
  Shared constants and types of the burst-of-two separate-port SRAM device.
  Assumes the includer compiles this package before every other design file.
*/
// Behaviour
// - Read address on true-clock edge, write address on complementary edge.
// - True clock edge captures read address, both selects and first write word.
// - Complementary edge captures write address, second word masks and second word.
// - Only byte lanes with asserted mask are written; other lanes keep data.
// - Write data is buffered until its write address arrives.
// - DLL on: first read word on complement edge two and a half cycles later.
// - DLL on: second read word on third true-clock edge after command.
// - Read data launched only from input clock pair edges.
// - Every access moves exactly two words at consecutive addresses.
// - Read port and write port work independently in the same cycle.
// - Accesses start at true-clock edge and complete self-timed.
// - Echo clock edges align with read data.
// - Valid indicator marks valid read data, aligned to echo clocks.
// - DLL bypass input low selects one-cycle read latency.
// - Address ignored while the port is deselected.
// - Echo clocks run continuously, also with data outputs off.
package bsp_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 36;
  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam int BURST = 2;
  localparam int ROW_W = DATA_W * BURST;
  localparam int MASK_W = LANES * BURST;
  localparam int DEPTH = 1 << ADDR_W;
  localparam int CORE_CLK_MHZ = 25;
  localparam int DLL_OFF_FMAX_MHZ = 167;
  localparam int DLL_ON_LAT_HALF = 5;
  localparam int DLL_OFF_LAT_HALF = 2;
  localparam int LOCK_CYCLES_DEF = 1024;
  localparam int LOCK_CNT_W = 16;
  localparam logic [DATA_W-1:0] RST_DATA = 36'h0_0000_0000;
  localparam logic [ADDR_W-1:0] RST_ADDR = 18'h0_0000;
  localparam logic [LANES-1:0] RST_MASK_N = 4'hf;
  localparam logic [LOCK_CNT_W-1:0] RST_LOCK_CNT = 16'h0000;

  typedef enum logic {BSP_LAT_ONE, BSP_LAT_TWO_HALF} bsp_lat_t;
  typedef enum logic [1:0] {BSP_DLL_BYPASS, BSP_DLL_LOCKING, BSP_DLL_LOCKED} bsp_dll_t;
endpackage

// [logic/bsp_sync2.sv]
/*
  Two flip-flop level synchroniser.
  Assumes the input is a level that stays put for several destination clocks.
*/
`timescale 1ns/1ps
module bsp_sync2 (
  input wire logic clk,
  input wire logic d,
  output logic q
);
  logic meta_ff;

  always_ff @(posedge clk) begin
    meta_ff <= d;
  end

  always_ff @(posedge clk) begin
    q <= meta_ff;
  end
endmodule

// [logic/bsp_array.sv]
/*
  Storage array: one row holds both words of a burst, one write and one
  registered read per clock.
  Assumes a read and a write of the same row in one edge return the old row.
*/
`timescale 1ns/1ps
module bsp_array (
  input wire logic clk,
  input wire logic we,
  input wire logic [bsp_pkg::ADDR_W-1:0] waddr,
  input wire logic [bsp_pkg::ROW_W-1:0] wdata,
  input wire logic [bsp_pkg::MASK_W-1:0] wlane_en,
  input wire logic re,
  input wire logic [bsp_pkg::ADDR_W-1:0] raddr,
  output logic [bsp_pkg::ROW_W-1:0] rdata
);
  import bsp_pkg::*;

  logic [ROW_W-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      for (int i = 0; i < MASK_W; i++) begin
        if (wlane_en[i]) begin
          mem[waddr][i*LANE_W +: LANE_W] <= wdata[i*LANE_W +: LANE_W];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (re) begin
      rdata <= mem[raddr];
    end
  end

  lane_keep_a: assert property (@(posedge clk)
    we && !wlane_en[0] |=> mem[$past(waddr)][LANE_W-1:0] == $past(mem[waddr][LANE_W-1:0]))
    else $error("masked lane was overwritten");
endmodule

// [logic/bsp_sram_port.sv]
/*
  Device-side logic of a separate-port, burst-of-two DDR static memory:
  command and data capture, write buffer, array access, read forwarding,
  read latency selection and DDR output launch with echo clocks.
  Assumes k_n_clk is the complement of k_clk, both running while rstn is
  released, and that the controller keeps its own pin timing.
*/
`timescale 1ns/1ps
module bsp_sram_port #(
  parameter int LOCK_CYCLES = bsp_pkg::LOCK_CYCLES_DEF
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic k_clk,
  input wire logic k_n_clk,
  input wire logic dll_bypass_n,
  input wire logic [bsp_pkg::ADDR_W-1:0] sync_addr,
  input wire logic rd_sel_n,
  input wire logic wr_sel_n,
  input wire logic [bsp_pkg::DATA_W-1:0] wr_data,
  input wire logic [bsp_pkg::LANES-1:0] lane_mask_n,
  output logic [bsp_pkg::DATA_W-1:0] rd_data,
  output logic rd_data_oe,
  output logic echo_timing_pos,
  output logic echo_timing_neg,
  output logic output_valid_ind
);
  import bsp_pkg::*;

  // Core domain: DLL lock tracking
  logic dll_bypass_n_s;
  bsp_dll_t dll_state_ff;
  bsp_dll_t nxt_dll_state;
  logic [LOCK_CNT_W-1:0] lock_cnt_ff;
  logic dll_locked_ff;

  // Link domain
  logic link_rst_n;
  logic dll_locked_s;
  bsp_lat_t lat_ff;
  logic lat_one;

  logic rd_go;
  logic rd_v_ff;
  logic [ADDR_W-1:0] rd_a_ff;
  logic rd1_v_ff;
  logic [ROW_W-1:0] rd1_data_ff;
  logic rd2_v_ff;
  logic [ROW_W-1:0] rd2_data_ff;

  logic wr0_v_ff;
  logic [DATA_W-1:0] wr0_data_ff;
  logic [LANES-1:0] wr0_mask_n_ff;
  logic wb_v_ff;
  logic [ADDR_W-1:0] wb_addr_ff;
  logic [DATA_W-1:0] wb_d0_ff;
  logic [DATA_W-1:0] wb_d1_ff;
  logic [LANES-1:0] wb_m0_n_ff;
  logic [LANES-1:0] wb_m1_n_ff;
  logic [ROW_W-1:0] wb_row;
  logic [MASK_W-1:0] wb_lane_en;

  logic fwd_hit_ff;
  logic [ROW_W-1:0] fwd_data_ff;
  logic [MASK_W-1:0] fwd_en_ff;
  logic [ROW_W-1:0] arr_rdata;
  logic [ROW_W-1:0] merged;

  logic q_pos_v_ff;
  logic [DATA_W-1:0] q_pos_ff;
  logic q_neg_v_ff;
  logic [DATA_W-1:0] q_neg_ff;

  // Core domain
  bsp_sync2 u_sync_bypass (
    .clk(core_clk),
    .d(dll_bypass_n),
    .q(dll_bypass_n_s)
  );

  always_comb begin
    nxt_dll_state = dll_state_ff;
    unique case (dll_state_ff)
      BSP_DLL_BYPASS: begin
        if (dll_bypass_n_s) begin
          nxt_dll_state = BSP_DLL_LOCKING;
        end
      end
      BSP_DLL_LOCKING: begin
        if (!dll_bypass_n_s) begin
          nxt_dll_state = BSP_DLL_BYPASS;
        end else if (lock_cnt_ff == LOCK_CNT_W'(LOCK_CYCLES - 1)) begin
          nxt_dll_state = BSP_DLL_LOCKED;
        end
      end
      BSP_DLL_LOCKED: begin
        if (!dll_bypass_n_s) begin
          nxt_dll_state = BSP_DLL_BYPASS;
        end
      end
      default: begin
        nxt_dll_state = BSP_DLL_BYPASS;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      dll_state_ff <= BSP_DLL_BYPASS;
    end else begin
      dll_state_ff <= nxt_dll_state;
    end
  end

  // Bypass clears the lock history
  always_ff @(posedge core_clk) begin
    if (!rstn || dll_state_ff != BSP_DLL_LOCKING) begin
      lock_cnt_ff <= RST_LOCK_CNT;
    end else begin
      lock_cnt_ff <= lock_cnt_ff + LOCK_CNT_W'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      dll_locked_ff <= 1'b0;
    end else begin
      dll_locked_ff <= (nxt_dll_state == BSP_DLL_LOCKED);
    end
  end

  // Crossings into the link domain
  bsp_sync2 u_sync_rst (
    .clk(k_clk),
    .d(rstn),
    .q(link_rst_n)
  );

  bsp_sync2 u_sync_lock (
    .clk(k_clk),
    .d(dll_locked_ff),
    .q(dll_locked_s)
  );

  always_ff @(posedge k_clk) begin
    if (!link_rst_n) begin
      lat_ff <= BSP_LAT_ONE;
    end else begin
      lat_ff <= dll_locked_s ? BSP_LAT_TWO_HALF : BSP_LAT_ONE;
    end
  end

  assign lat_one = (lat_ff == BSP_LAT_ONE);

  // Read command on the true clock
  assign rd_go = !rd_sel_n;

  always_ff @(posedge k_clk) begin
    if (!link_rst_n) begin
      rd_v_ff <= 1'b0;
    end else begin
      rd_v_ff <= rd_go;
    end
  end

  // Address ignored when deselected
  always_ff @(posedge k_clk) begin
    if (!link_rst_n) begin
      rd_a_ff <= RST_ADDR;
    end else if (rd_go) begin
      rd_a_ff <= sync_addr;
    end
  end

  // Write command and first word on the true clock
  always_ff @(posedge k_clk) begin
    if (!link_rst_n) begin
      wr0_v_ff <= 1'b0;
    end else begin
      wr0_v_ff <= !wr_sel_n;
    end
  end

  always_ff @(posedge k_clk) begin
    if (!link_rst_n) begin
      wr0_data_ff <= RST_DATA;
      wr0_mask_n_ff <= RST_MASK_N;
    end else if (!wr_sel_n) begin
      wr0_data_ff <= wr_data;
      wr0_mask_n_ff <= lane_mask_n;
    end
  end

  // Write buffer: completed on the complementary clock
  always_ff @(posedge k_n_clk) begin
    if (!link_rst_n) begin
      wb_v_ff <= 1'b0;
    end else begin
      wb_v_ff <= wr0_v_ff;
    end
  end

  always_ff @(posedge k_n_clk) begin
    if (!link_rst_n) begin
      wb_addr_ff <= RST_ADDR;
      wb_d0_ff <= RST_DATA;
      wb_d1_ff <= RST_DATA;
      wb_m0_n_ff <= RST_MASK_N;
      wb_m1_n_ff <= RST_MASK_N;
    end else if (wr0_v_ff) begin
      wb_addr_ff <= sync_addr;
      wb_d1_ff <= wr_data;
      wb_m1_n_ff <= lane_mask_n;
      wb_d0_ff <= wr0_data_ff;
      wb_m0_n_ff <= wr0_mask_n_ff;
    end
  end

  // Both words of a burst share one row
  assign wb_row = {wb_d1_ff, wb_d0_ff};
  assign wb_lane_en = ~{wb_m1_n_ff, wb_m0_n_ff};

  // Independent ports, self-timed commit
  bsp_array u_array (
    .clk(k_clk),
    .we(wb_v_ff),
    .waddr(wb_addr_ff),
    .wdata(wb_row),
    .wlane_en(wb_lane_en),
    .re(rd_go),
    .raddr(sync_addr),
    .rdata(arr_rdata)
  );

  // Catch a write that commits on the same edge as the read
  always_ff @(posedge k_clk) begin
    if (!link_rst_n) begin
      fwd_hit_ff <= 1'b0;
    end else begin
      fwd_hit_ff <= rd_go && wb_v_ff && (wb_addr_ff == sync_addr);
    end
  end

  always_ff @(posedge k_clk) begin
    if (!link_rst_n) begin
      fwd_data_ff <= {RST_DATA, RST_DATA};
      fwd_en_ff <= '0;
    end else begin
      fwd_data_ff <= wb_row;
      fwd_en_ff <= wb_lane_en;
    end
  end

  always_comb begin
    merged = arr_rdata;
    for (int i = 0; i < MASK_W; i++) begin
      if (fwd_hit_ff && fwd_en_ff[i]) begin
        merged[i*LANE_W +: LANE_W] = fwd_data_ff[i*LANE_W +: LANE_W];
      end
    end
  end

  // Read pipeline
  always_ff @(posedge k_clk) begin
    if (!link_rst_n) begin
      rd1_v_ff <= 1'b0;
      rd2_v_ff <= 1'b0;
    end else begin
      rd1_v_ff <= rd_v_ff;
      rd2_v_ff <= rd1_v_ff;
    end
  end

  always_ff @(posedge k_clk) begin
    if (!link_rst_n) begin
      rd1_data_ff <= {RST_DATA, RST_DATA};
      rd2_data_ff <= {RST_DATA, RST_DATA};
    end else begin
      rd1_data_ff <= merged;
      rd2_data_ff <= rd1_data_ff;
    end
  end

  // True-clock launch: word 0 in one-cycle mode, word 1 otherwise
  always_ff @(posedge k_clk) begin
    if (!link_rst_n) begin
      q_pos_v_ff <= 1'b0;
      q_pos_ff <= RST_DATA;
    end else if (lat_one) begin
      q_pos_v_ff <= rd_v_ff;
      q_pos_ff <= merged[DATA_W-1:0];
    end else begin
      q_pos_v_ff <= rd2_v_ff;
      q_pos_ff <= rd2_data_ff[ROW_W-1:DATA_W];
    end
  end

  // Complement-clock launch: word 1 in one-cycle mode, word 0 otherwise
  always_ff @(posedge k_n_clk) begin
    if (!link_rst_n) begin
      q_neg_v_ff <= 1'b0;
      q_neg_ff <= RST_DATA;
    end else if (lat_one) begin
      q_neg_v_ff <= rd1_v_ff;
      q_neg_ff <= rd1_data_ff[ROW_W-1:DATA_W];
    end else begin
      q_neg_v_ff <= rd2_v_ff;
      q_neg_ff <= rd2_data_ff[DATA_W-1:0];
    end
  end

  // DDR output: the most recent launching edge selects the register
  assign rd_data = k_clk ? q_pos_ff : q_neg_ff;
  assign output_valid_ind = k_clk ? q_pos_v_ff : q_neg_v_ff;
  assign rd_data_oe = output_valid_ind;
  assign echo_timing_pos = k_clk;
  assign echo_timing_neg = k_n_clk;

  // Checks
  sequence rd_two_half_s;
    (rd_v_ff && !lat_one) ##1 !lat_one ##1 !lat_one;
  endsequence

  rd_take_a: assert property (@(posedge k_clk) disable iff (!link_rst_n)
    rd_v_ff |-> rd_a_ff == $past(sync_addr) && !$past(rd_sel_n))
    else $error("read command or address not captured");

  both_ports_a: assert property (@(posedge k_clk) disable iff (!link_rst_n)
    !rd_sel_n && !wr_sel_n |=> rd_v_ff && wr0_v_ff ##1 rd1_v_ff)
    else $error("concurrent read and write not both taken");

  wr_buffer_a: assert property (@(posedge k_clk) disable iff (!link_rst_n)
    wr0_v_ff |-> wb_v_ff && wb_d0_ff == $past(wr_data))
    else $error("buffered write not committed one cycle later");

  wr_addr_a: assert property (@(posedge k_n_clk) disable iff (!link_rst_n)
    wr0_v_ff |=> wb_v_ff && wb_addr_ff == $past(sync_addr) && wb_d1_ff == $past(wr_data))
    else $error("write address or second word not captured");

  lat_word1_a: assert property (@(posedge k_clk) disable iff (!link_rst_n)
    rd_two_half_s |=> q_pos_v_ff && q_pos_ff == $past(rd2_data_ff[ROW_W-1:DATA_W]))
    else $error("second read word not on third true edge");

  lat_word0_a: assert property (@(posedge k_n_clk) disable iff (!link_rst_n)
    rd2_v_ff && !lat_one |=> q_neg_v_ff && q_neg_ff == $past(rd2_data_ff[DATA_W-1:0]))
    else $error("first read word not two and a half cycles late");

  lat_off_a: assert property (@(posedge k_clk) disable iff (!link_rst_n)
    rd_v_ff && lat_one |=> q_pos_v_ff && q_pos_ff == $past(merged[DATA_W-1:0]))
    else $error("one-cycle read word missing");

  fwd_merge_a: assert property (@(posedge k_clk) disable iff (!link_rst_n)
    fwd_hit_ff && fwd_en_ff[0] |-> merged[LANE_W-1:0] == fwd_data_ff[LANE_W-1:0])
    else $error("pending write not forwarded to read");

  idle_quiet_a: assert property (@(posedge k_clk) disable iff (!link_rst_n)
    !rd_v_ff && !rd1_v_ff && !rd2_v_ff |=> !q_pos_v_ff)
    else $error("valid raised without a read");
endmodule

// [verif/bsp_ctrl_model.sv]
/*
  Behavioural memory controller: runs the K/K# clock pair and drives read and
  write commands, burst data and lane masks, one burst command per K cycle.
  Assumes the bench calls op once per K cycle, idle ops included.
*/
`timescale 1ns/1ps
module bsp_ctrl_model (
  output logic k_clk,
  output logic k_n_clk,
  output logic [bsp_pkg::ADDR_W-1:0] sync_addr,
  output logic rd_sel_n,
  output logic wr_sel_n,
  output logic [bsp_pkg::DATA_W-1:0] wr_data,
  output logic [bsp_pkg::LANES-1:0] lane_mask_n
);
  import bsp_pkg::*;
  initial begin
    k_clk = 1'b0;
    rd_sel_n = 1'b1;
    wr_sel_n = 1'b1;
    sync_addr = 18'h0_0000;
    wr_data = 36'h0_0000_0000;
    lane_mask_n = 4'hf;
    #7;
    forever #24 k_clk = ~k_clk;
  end
  assign k_n_clk = ~k_clk;

  // Unused address and data fields get the inverse of the last value
  task automatic op(input logic rd, input logic [ADDR_W-1:0] ra, input logic wr, input logic [ADDR_W-1:0] wa,
                    input logic [DATA_W-1:0] d0, input logic [DATA_W-1:0] d1,
                    input logic [LANES-1:0] m0, input logic [LANES-1:0] m1);
    @(posedge k_n_clk);
    rd_sel_n <= ~rd;
    wr_sel_n <= ~wr;
    sync_addr <= rd ? ra : ~sync_addr;
    wr_data <= wr ? d0 : ~wr_data;
    lane_mask_n <= m0;
    @(posedge k_clk);
    sync_addr <= wr ? wa : ~sync_addr;
    wr_data <= wr ? d1 : ~wr_data;
    lane_mask_n <= m1;
  endtask
endmodule

// [verif/tb.sv]
/*
  Self-checking bench of the burst-of-two separate-port memory device.
  Assumes the controller model drives the link side and a reference row array
  in the bench predicts every read burst.
*/
`timescale 1ns/1ps
module tb;
  import bsp_pkg::*;
  logic core_clk, rstn, dll_bypass_n, k_clk, k_n_clk, rd_sel_n, wr_sel_n;
  logic [ADDR_W-1:0] sync_addr;
  logic [DATA_W-1:0] wr_data, rd_data;
  logic [LANES-1:0] lane_mask_n;
  logic rd_data_oe, echo_timing_pos, echo_timing_neg, output_valid_ind;
  logic [ROW_W-1:0] mem [16];
  logic [ROW_W-1:0] exp_q [$];
  int t_q [$];
  int err_total, samples_checked, hcnt, lat, cyc, seed;
  logic ph;

  bsp_sram_port #(.LOCK_CYCLES(8)) u_dut (.core_clk(core_clk), .rstn(rstn), .k_clk(k_clk), .k_n_clk(k_n_clk),
    .dll_bypass_n(dll_bypass_n), .sync_addr(sync_addr), .rd_sel_n(rd_sel_n), .wr_sel_n(wr_sel_n),
    .wr_data(wr_data), .lane_mask_n(lane_mask_n), .rd_data(rd_data), .rd_data_oe(rd_data_oe),
    .echo_timing_pos(echo_timing_pos), .echo_timing_neg(echo_timing_neg), .output_valid_ind(output_valid_ind));
  bsp_ctrl_model u_ctl (.k_clk(k_clk), .k_n_clk(k_n_clk), .sync_addr(sync_addr), .rd_sel_n(rd_sel_n),
    .wr_sel_n(wr_sel_n), .wr_data(wr_data), .lane_mask_n(lane_mask_n));

  always #20 core_clk = ~core_clk;

  task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] s);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic final_report();
    $display("checked %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  function automatic logic [ADDR_W-1:0] af(input int i);
    return (i == 15) ? 18'h3_ffff : 18'(i);
  endfunction

  function automatic logic [35:0] r36();
    logic [63:0] t;
    t = {$urandom(), $urandom()};
    return t[35:0];
  endfunction

  // Reference row: mask low writes the lane
  task automatic do_op(input logic rd, input int ri, input logic wr, input int wi, input logic [35:0] d0,
                       input logic [35:0] d1, input logic [3:0] m0, input logic [3:0] m1);
    if (rd) exp_q.push_back(mem[ri]);
    if (wr) begin
      for (int l = 0; l < LANES; l++) begin
        if (!m0[l]) mem[wi][l*LANE_W +: LANE_W] = d0[l*LANE_W +: LANE_W];
        if (!m1[l]) mem[wi][DATA_W + l*LANE_W +: LANE_W] = d1[l*LANE_W +: LANE_W];
      end
    end
    u_ctl.op(rd, af(ri), wr, af(wi), d0, d1, m0, m1);
  endtask

  task automatic idle(input int n);
    repeat (n) do_op(1'b0, 0, 1'b0, 0, r36(), r36(), 4'(r36()), 4'(r36()));
  endtask

  always @(posedge k_clk or posedge k_n_clk) begin
    hcnt = hcnt + 1;
    if (k_clk === 1'b1 && rd_sel_n === 1'b0) t_q.push_back(hcnt);
    #12;
    chk("echo_pos", {35'h0, k_clk}, {35'h0, echo_timing_pos});
    chk("echo_neg", {35'h0, k_n_clk}, {35'h0, echo_timing_neg});
    // Outputs are unknown until the link reset has reached them
    if (rstn === 1'b1) begin
      chk("oe", {35'h0, output_valid_ind}, {35'h0, rd_data_oe});
      if (exp_q.size() > 0 && t_q.size() > 0 && (ph || hcnt - t_q[0] == lat)) begin
        chk("valid", 36'h1, {35'h0, output_valid_ind});
        if (!ph) chk("word0", exp_q[0][35:0], rd_data);
        else begin
          chk("word1", exp_q[0][71:36], rd_data);
          void'(exp_q.pop_front());
          void'(t_q.pop_front());
        end
        ph = ~ph;
      end else begin
        chk("valid", 36'h0, {35'h0, output_valid_ind});
      end
    end
  end

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      final_report();
    end
  end

  initial begin
    core_clk = 1'b0;
    rstn = 1'b0;
    dll_bypass_n = 1'b0;
    lat = 2;
    ph = 1'b0;
    seed = $urandom(32'hceaad607);
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    idle(6);
    for (int i = 0; i < 16; i++) do_op(1'b0, 0, 1'b1, i, r36(), r36(), 4'h0, 4'h0);
    // Drop both selects before the mode gap, or the last write repeats
    idle(2);
    for (int m = 0; m < 3; m++) begin
      @(posedge core_clk);
      dll_bypass_n <= m[0];
      repeat (40) @(posedge core_clk);
      lat = m[0] ? DLL_ON_LAT_HALF : DLL_OFF_LAT_HALF;
      // Read on write edge sees old row, next edge sees new lanes
      do_op(1'b1, 3, 1'b1, 3, r36(), r36(), 4'h5, 4'ha);
      do_op(1'b1, 3, 1'b0, 0, r36(), r36(), 4'h0, 4'h0);
      do_op(1'b1, 15, 1'b1, 15, r36(), r36(), 4'hf, 4'h0);
      do_op(1'b1, 15, 1'b0, 15, r36(), r36(), 4'h0, 4'h0);
      repeat (40) do_op(1'($urandom_range(1)), $urandom_range(15), 1'($urandom_range(1)), $urandom_range(15),
                        r36(), r36(), 4'(r36()), 4'(r36()));
      idle(8);
    end
    chk("drained", 36'h0, 36'(exp_q.size()));
    final_report();
  end
endmodule
